// File: lsp_pkg.sv
package lsp_pkg;
   localparam int          LSP_BITS       = 12;
   localparam int          LSP_UPAT_LEN   = 8;
   localparam int          LSP_IDX_W      = 3;
   localparam int          LSP_ADDR_W     = 12;
   localparam int          LSP_CFG_W      = 10;

   // register byte offsets
   localparam logic [11:0] LSP_OFS_CTRL   = 12'h000;
   localparam logic [11:0] LSP_OFS_TSRC   = 12'h004;
   localparam logic [11:0] LSP_OFS_STAT   = 12'h008;
   localparam logic [11:0] LSP_OFS_UPAT   = 12'h020;

   // output_control_reg fields
   localparam int          LSP_CTRL_WHITEN = 0;
   localparam int          LSP_CTRL_WIDTH  = 1;
   localparam int          LSP_CTRL_MARKER = 3;
   localparam int          LSP_CTRL_LSBSEL = 4;
   localparam int          LSP_CTRL_TOGSRC = 5;
   localparam int          LSP_CTRL_SWTOG  = 6;
   localparam logic [6:0]  LSP_CTRL_RST    = 7'h00;

   // test_source_reg fields
   localparam int          LSP_TSRC_NORMAL = 0;
   localparam int          LSP_TSRC_ALIGN  = 1;
   localparam logic [2:0]  LSP_TSRC_RST    = 3'h0;

   // status fields
   localparam int          LSP_STAT_SYNC   = 0;
   localparam int          LSP_STAT_PIN    = 1;

   localparam logic [11:0] LSP_UPAT_RST    = 12'h000;

   // sample_width_sel codes
   localparam logic [1:0]  LSP_W12        = 2'h0;
   localparam logic [1:0]  LSP_W11        = 2'h1;
   localparam logic [1:0]  LSP_W10        = 2'h2;
   localparam logic [1:0]  LSP_W8         = 2'h3;

   // align_pattern_choice codes
   localparam logic [1:0]  LSP_ALN_USER   = 2'h0;
   localparam logic [1:0]  LSP_ALN_ALL    = 2'h1;
   localparam logic [1:0]  LSP_ALN_LSB    = 2'h2;

   // toggle source and lsb select codes
   localparam logic        LSP_TOG_PIN    = 1'b0;
   localparam logic        LSP_LSB_MARKER = 1'b0;
endpackage

// File: lsp_scrambler.sv
`timescale 1ns/1ps
module lsp_scrambler
   import lsp_pkg::*;
(
   input  wire logic [lsp_pkg::LSP_BITS-1:0] i_data,
   input  wire logic                         i_strobe,
   input  wire logic                         i_enable,
   input  wire logic [1:0]                   i_width,
   output logic      [lsp_pkg::LSP_BITS-1:0] o_data,
   output logic                              o_strobe
);
   import lsp_pkg::*;

   // no state at all: xor of the current sample only [RULE_02]
   always_comb begin
      o_data   = i_data;                                  // [RULE_19]
      o_strobe = i_strobe;
      if (i_enable) begin                                 // [RULE_01]
         case (i_width)
            LSP_W12: begin                                // [RULE_03]
               for (int k = 2; k < LSP_BITS; k++) o_data[k] = i_data[k] ^ i_data[1] ^ i_data[0];
               o_data[1] = i_data[1];
               o_data[0] = i_data[0] ^ i_data[1];
               o_strobe  = i_strobe ^ i_data[1] ^ i_data[0];
            end
            LSP_W11: begin                                // [RULE_05]
               for (int k = 3; k < LSP_BITS; k++) o_data[k] = i_data[k] ^ i_data[2] ^ i_data[1];
               o_data[2] = i_data[2];
               o_data[1] = i_data[2] ^ i_data[1];
               o_data[0] = i_data[2] ^ i_data[1] ^ i_data[0];
               o_strobe  = i_strobe ^ i_data[1] ^ i_data[0];
            end
            LSP_W10: begin                                // [RULE_07]
               for (int k = 4; k < LSP_BITS; k++) o_data[k] = i_data[k] ^ i_data[3] ^ i_data[2];
               o_data[3] = i_data[3];
               o_data[2] = i_data[2] ^ i_data[3];
               o_data[1] = 1'b0;
               o_data[0] = i_data[0] ^ i_data[3] ^ i_data[2];
               o_strobe  = i_strobe ^ i_data[3] ^ i_data[2];
            end
            default: begin                                // [RULE_09]
               for (int k = 6; k < LSP_BITS; k++) o_data[k] = i_data[k] ^ i_data[5] ^ i_data[4];
               o_data[5]   = i_data[5];
               o_data[4]   = i_data[4] ^ i_data[5];
               o_data[3:1] = 3'h0;
               o_data[0]   = i_data[0] ^ i_data[5] ^ i_data[4];
               o_strobe    = i_strobe ^ i_data[5] ^ i_data[4];
            end
         endcase
      end
   end
endmodule // lsp_scrambler

// File: lsp_output_top.sv
`timescale 1ns/1ps
// Overview of operation
// RULE_01 - scramble only while whitening enable set
// RULE_02 - scrambler is stateless xor of sample
// RULE_03 - twelve-bit width scrambling equations
// RULE_04 - receiver descrambles twelve-bit width
// RULE_05 - eleven-bit width scrambling equations
// RULE_06 - receiver descrambles eleven-bit width
// RULE_07 - ten-bit width scrambling, bit one zero
// RULE_08 - receiver descrambles ten-bit width
// RULE_09 - eight-bit width scrambling, bits 3:1 zero
// RULE_10 - receiver descrambles eight-bit width
// RULE_11 - reduced widths: bit zero only with marker
// RULE_12 - bit k on pair k, strobe on strobe
// RULE_13 - marker on lsb stays reversible
// RULE_14 - active/sync chosen by selectable toggle source
// RULE_15 - pattern switches only at strobe falling edge
// RULE_16 - active pattern: samples or user pattern
// RULE_17 - sync pattern: user, lsb strobe, all strobe
// RULE_18 - user pattern restarts each frame, repeats
// RULE_19 - whitening off passes pattern bits unchanged
module lsp_output_top
   import lsp_pkg::*;
#(
   parameter int NUM_BUS = 4
) (
   input  wire logic                                 i_clk,
   input  wire logic                                 i_reset,
   input  wire logic                                 i_psel,
   input  wire logic                                 i_penable,
   input  wire logic                                 i_pwrite,
   input  wire logic [lsp_pkg::LSP_ADDR_W-1:0]       i_paddr,
   input  wire logic [31:0]                          i_pwdata,
   output logic      [31:0]                          o_prdata,
   output logic                                      o_pready,
   output logic                                      o_pslverr,
   input  wire logic                                 i_link_clk,
   input  wire logic [NUM_BUS*lsp_pkg::LSP_BITS-1:0] i_sample,
   input  wire logic [NUM_BUS-1:0]                   i_strobe,
   input  wire logic [NUM_BUS-1:0]                   i_marker,
   input  wire logic                                 i_pattern_toggle_pin,
   output logic      [NUM_BUS*lsp_pkg::LSP_BITS-1:0] o_lane_data,
   output logic      [NUM_BUS-1:0]                   o_bus_strobe_lane
);
   import lsp_pkg::*;

   localparam int UPAT_W = LSP_UPAT_LEN * LSP_BITS;

   logic [6:0]           output_control_reg_ff;
   logic [2:0]           test_source_reg_ff;
   logic [LSP_BITS-1:0]  upat_ff [LSP_UPAT_LEN];
   logic [UPAT_W-1:0]    upat_flat;
   logic [31:0]          prdata_ff;
   logic                 pslverr_ff;
   logic [31:0]          nxt_prdata;
   logic                 nxt_pslverr;
   logic                 wr_en;
   logic                 upat_hit;
   logic [1:0]           stat_s1_ff;
   logic [1:0]           stat_s2_ff;

   // link-domain state
   logic                 lrst_s1_ff;
   logic                 lrst_ff;
   logic                 lrst_d_ff;
   logic [LSP_CFG_W-1:0] cfg_s1_ff;
   logic [LSP_CFG_W-1:0] cfg_ff;
   logic [UPAT_W-1:0]    upat_s1_ff;
   logic [UPAT_W-1:0]    upat_l_ff;
   logic                 pin_s1_ff;
   logic                 pin_ff;
   logic                 strobe_prev_ff;
   logic                 sync_mode_ff;
   logic [LSP_IDX_W-1:0] idx_ff;
   logic                 frame_start;
   logic                 req_sync;
   logic                 cur_sync;
   logic [LSP_IDX_W-1:0] cur_idx;
   logic [LSP_BITS-1:0]  cur_upat;
   logic                 cfg_whiten;
   logic [1:0]           cfg_width;
   logic                 cfg_marker;
   logic                 cfg_lsbsel;
   logic                 cfg_togsrc;
   logic                 cfg_swtog;
   logic                 cfg_normal;
   logic [1:0]           cfg_align;
   logic                 lsb_live;
   logic [LSP_BITS-1:0]  pre_data  [NUM_BUS];
   logic [LSP_BITS-1:0]  scr_data  [NUM_BUS];
   logic                 scr_strobe[NUM_BUS];
   logic [LSP_BITS-1:0]  lane_ff   [NUM_BUS];
   logic                 stb_ff    [NUM_BUS];

   // ---------------- apb slave, i_clk domain ----------------
   // zero wait states; read data is picked in the setup cycle so it comes from a flop
   assign o_pready  = i_psel & i_penable;
   assign o_prdata  = prdata_ff;
   assign o_pslverr = pslverr_ff;
   assign wr_en     = i_psel & i_penable & i_pwrite;
   assign upat_hit  = (i_paddr[LSP_ADDR_W-1:5] == LSP_OFS_UPAT[LSP_ADDR_W-1:5]);

   always_comb begin
      nxt_prdata  = 32'h0000_0000;
      nxt_pslverr = 1'b0;
      if (upat_hit) begin
         nxt_prdata[LSP_BITS-1:0] = upat_ff[i_paddr[4:2]];
      end else begin
         case (i_paddr)
            LSP_OFS_CTRL: nxt_prdata[6:0] = output_control_reg_ff;
            LSP_OFS_TSRC: nxt_prdata[2:0] = test_source_reg_ff;
            LSP_OFS_STAT: nxt_prdata[1:0] = stat_s2_ff;
            default:      nxt_pslverr     = 1'b1;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else if (i_psel & ~i_penable) begin
         prdata_ff  <= i_pwrite ? 32'h0000_0000 : nxt_prdata;
         pslverr_ff <= nxt_pslverr;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         output_control_reg_ff <= LSP_CTRL_RST;
         test_source_reg_ff    <= LSP_TSRC_RST;
      end else if (wr_en & ~upat_hit) begin
         if (i_paddr == LSP_OFS_CTRL) output_control_reg_ff <= i_pwdata[6:0];
         if (i_paddr == LSP_OFS_TSRC) test_source_reg_ff    <= i_pwdata[2:0];
      end
   end

   generate
      for (genvar u = 0; u < LSP_UPAT_LEN; u++) begin : g_upat
         always_ff @(posedge i_clk) begin
            if (i_reset) begin
               upat_ff[u] <= LSP_UPAT_RST;
            end else if (wr_en & upat_hit & (i_paddr[4:2] == 3'(u))) begin
               upat_ff[u] <= i_pwdata[LSP_BITS-1:0];
            end
         end
         assign upat_flat[u*LSP_BITS +: LSP_BITS] = upat_ff[u];
      end
   endgenerate

   // link status back into the bus domain
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         stat_s1_ff <= 2'h0;
         stat_s2_ff <= 2'h0;
      end else begin
         stat_s1_ff <= {pin_ff, sync_mode_ff};
         stat_s2_ff <= stat_s1_ff;
      end
   end

   // ---------------- link domain ----------------
   // config bits cross as levels; change them only while the link output is not in use
   always_ff @(posedge i_link_clk) begin
      lrst_s1_ff <= i_reset;
      lrst_ff    <= lrst_s1_ff;
      // checks stay off one cycle longer so $past never looks into reset
      lrst_d_ff  <= lrst_ff;
   end

   always_ff @(posedge i_link_clk) begin
      cfg_s1_ff  <= {test_source_reg_ff, output_control_reg_ff};
      cfg_ff     <= cfg_s1_ff;
      upat_s1_ff <= upat_flat;
      upat_l_ff  <= upat_s1_ff;
      pin_s1_ff  <= i_pattern_toggle_pin;
      pin_ff     <= pin_s1_ff;
   end

   assign cfg_whiten = cfg_ff[LSP_CTRL_WHITEN];
   assign cfg_width  = cfg_ff[LSP_CTRL_WIDTH +: 2];
   assign cfg_marker = cfg_ff[LSP_CTRL_MARKER];
   assign cfg_lsbsel = cfg_ff[LSP_CTRL_LSBSEL];
   assign cfg_togsrc = cfg_ff[LSP_CTRL_TOGSRC];
   assign cfg_swtog  = cfg_ff[LSP_CTRL_SWTOG];
   assign cfg_normal = cfg_ff[7 + LSP_TSRC_NORMAL];
   assign cfg_align  = cfg_ff[7 + LSP_TSRC_ALIGN +: 2];

   // pin by default, software bit when chosen [RULE_14]
   assign req_sync    = (cfg_togsrc == LSP_TOG_PIN) ? pin_ff : cfg_swtog;
   // frame boundary: strobe of bus 0 falling
   assign frame_start = strobe_prev_ff & ~i_strobe[0];
   assign cur_sync    = frame_start ? req_sync : sync_mode_ff;             // [RULE_15]
   assign cur_idx     = frame_start ? {LSP_IDX_W{1'b0}} : idx_ff;          // [RULE_18]
   assign cur_upat    = upat_l_ff[cur_idx*LSP_BITS +: LSP_BITS];
   assign lsb_live    = (cfg_lsbsel == LSP_LSB_MARKER) & cfg_marker;

   always_ff @(posedge i_link_clk) begin
      if (lrst_ff) begin
         strobe_prev_ff <= 1'b0;
         sync_mode_ff   <= 1'b0;
      end else begin
         strobe_prev_ff <= i_strobe[0];
         sync_mode_ff   <= cur_sync;                                      // [RULE_15]
      end
   end

   // wraps after the eighth sample so long frames repeat, short ones truncate
   always_ff @(posedge i_link_clk) begin
      if (lrst_ff) begin
         idx_ff <= {LSP_IDX_W{1'b0}};
      end else begin
         idx_ff <= cur_idx + 3'h1;                                         // [RULE_18]
      end
   end

   generate
      for (genvar b = 0; b < NUM_BUS; b++) begin : g_bus
         logic [LSP_BITS-1:0] smp;

         always_comb begin
            smp = i_sample[b*LSP_BITS +: LSP_BITS];
            if (lsb_live) smp[0] = i_marker[b];                            // [RULE_13]
            if (!cur_sync) begin
               pre_data[b] = cfg_normal ? cur_upat : smp;                  // [RULE_16]
            end else begin
               case (cfg_align)                                            // [RULE_17]
                  LSP_ALN_ALL: pre_data[b] = {LSP_BITS{i_strobe[b]}};
                  LSP_ALN_LSB: pre_data[b] = {smp[LSP_BITS-1:1], i_strobe[b]};
                  default:     pre_data[b] = cur_upat;
               endcase
            end
         end

         lsp_scrambler u_scr (
            .i_data   (pre_data[b]),
            .i_strobe (i_strobe[b]),
            .i_enable (cfg_whiten),
            .i_width  (cfg_width),
            .o_data   (scr_data[b]),
            .o_strobe (scr_strobe[b])
         );

         always_ff @(posedge i_link_clk) begin
            if (lrst_ff) begin
               lane_ff[b] <= {LSP_BITS{1'b0}};
               stb_ff[b]  <= 1'b0;
            end else begin
               lane_ff[b]    <= scr_data[b];
               // whitened reduced widths: lsb lane idles low unless it carries the marker
               if (cfg_whiten && (cfg_width != LSP_W12) && !lsb_live) begin
                  lane_ff[b][0] <= 1'b0;                                   // [RULE_11]
               end
               stb_ff[b] <= scr_strobe[b];
            end
         end

         assign o_lane_data[b*LSP_BITS +: LSP_BITS] = lane_ff[b];         // [RULE_12]
         assign o_bus_strobe_lane[b]                = stb_ff[b];           // [RULE_12]
      end
   endgenerate

   // ---------------- checks, link domain ----------------
   default clocking cb @(posedge i_link_clk); endclocking
   default disable iff (lrst_ff | lrst_d_ff);

   property p_plain_pass;
      !cfg_whiten |=> (lane_ff[0] == $past(pre_data[0])) && (stb_ff[0] == $past(i_strobe[0]));
   endproperty
   a_plain_pass: assert property (p_plain_pass) else $error("whitening off altered lanes"); // [RULE_19]

   property p_w12;
      cfg_whiten && (cfg_width == LSP_W12) |=>
         (lane_ff[0][1] == $past(pre_data[0][1])) &&
         (lane_ff[0][0] == ($past(pre_data[0][0]) ^ $past(pre_data[0][1]))) &&
         (lane_ff[0][7] == ($past(pre_data[0][7]) ^ $past(pre_data[0][1]) ^ $past(pre_data[0][0])));
   endproperty
   a_w12: assert property (p_w12) else $error("twelve-bit scramble wrong"); // [RULE_03]

   property p_w11;
      cfg_whiten && (cfg_width == LSP_W11) |=>
         (lane_ff[0][2] == $past(pre_data[0][2])) &&
         (lane_ff[0][1] == ($past(pre_data[0][2]) ^ $past(pre_data[0][1])));
   endproperty
   a_w11: assert property (p_w11) else $error("eleven-bit scramble wrong"); // [RULE_05]

   property p_w10;
      cfg_whiten && (cfg_width == LSP_W10) |=>
         (lane_ff[0][1] == 1'b0) && (lane_ff[0][3] == $past(pre_data[0][3]));
   endproperty
   a_w10: assert property (p_w10) else $error("ten-bit scramble wrong"); // [RULE_07]

   property p_w8;
      cfg_whiten && (cfg_width == LSP_W8) |=>
         (lane_ff[0][3:1] == 3'h0) &&
         (stb_ff[0] == ($past(i_strobe[0]) ^ $past(pre_data[0][5]) ^ $past(pre_data[0][4])));
   endproperty
   a_w8: assert property (p_w8) else $error("eight-bit scramble wrong"); // [RULE_09]

   property p_lsb_idle;
      cfg_whiten && (cfg_width != LSP_W12) && !lsb_live |=> (lane_ff[0][0] == 1'b0);
   endproperty
   a_lsb_idle: assert property (p_lsb_idle) else $error("reduced-width lsb not idle"); // [RULE_11]

   property p_switch_at_frame;
      $changed(sync_mode_ff) |-> $past(frame_start);
   endproperty
   a_switch_at_frame: assert property (p_switch_at_frame) else $error("pattern switched mid-frame"); // [RULE_15]

   property p_upat_restart;
      frame_start |=> (idx_ff == 3'h1);
   endproperty
   a_upat_restart: assert property (p_upat_restart) else $error("user pattern did not restart"); // [RULE_18]

   property p_all_strobe;
      !cfg_whiten && cur_sync && (cfg_align == LSP_ALN_ALL) |=>
         (lane_ff[0] == {LSP_BITS{$past(i_strobe[0])}});
   endproperty
   a_all_strobe: assert property (p_all_strobe) else $error("strobe not on all lanes"); // [RULE_17]

   property p_normal_user;
      !cfg_whiten && !cur_sync && cfg_normal |=> (lane_ff[0] == $past(cur_upat));
   endproperty
   a_normal_user: assert property (p_normal_user) else $error("user pattern not selected"); // [RULE_16]

   c_enter_sync:  cover property (frame_start && req_sync && !sync_mode_ff);
   c_w8_scramble: cover property (cfg_whiten && (cfg_width == LSP_W8));
   c_upat_wrap:   cover property ((idx_ff == 3'h7) ##1 (idx_ff == 3'h0));
endmodule // lsp_output_top

// File: lsp_rx_model.sv
`timescale 1ns/1ps
module lsp_rx_model
   import lsp_pkg::*;
#(
   parameter int NUM_BUS = 4
) (
   input  wire logic [NUM_BUS*lsp_pkg::LSP_BITS-1:0] i_lane_data,
   input  wire logic [NUM_BUS-1:0]                   i_bus_strobe_lane,
   input  wire logic [1:0]                           i_width,
   output logic      [NUM_BUS*lsp_pkg::LSP_BITS-1:0] o_data,
   output logic      [NUM_BUS-1:0]                   o_strobe
);
   import lsp_pkg::*;

   // memoryless receiver, so a glitch on one sample never spreads to the next
   function automatic logic [12:0] desc(input logic [11:0] y, input logic s, input logic [1:0] wd);
      logic [11:0] d;
      logic        t;
      d = y;
      case (wd)
         LSP_W12: begin
            for (int k = 2; k < 12; k++) d[k] = y[k] ^ y[0];
            d[0] = y[0] ^ y[1];
            t = s ^ y[0];
         end
         LSP_W11: begin
            for (int k = 3; k < 12; k++) d[k] = y[k] ^ y[1];
            d[1] = y[2] ^ y[1];
            d[0] = y[1] ^ y[0];
            t = s ^ y[1];
         end
         LSP_W10: begin
            for (int k = 4; k < 12; k++) d[k] = y[k] ^ y[2];
            d[2] = y[2] ^ y[3];
            d[1] = 1'b0;
            d[0] = y[0] ^ y[2];
            t = s ^ y[2];
         end
         default: begin
            for (int k = 6; k < 12; k++) d[k] = y[k] ^ y[4];
            d[4] = y[4] ^ y[5];
            d[3:1] = 3'h0;
            d[0] = y[0] ^ y[4];
            t = s ^ y[4];
         end
      endcase
      return {t, d};
   endfunction

   for (genvar b = 0; b < NUM_BUS; b++) begin : g_bus
      // lane k of bus b and that bus's own strobe pair
      assign {o_strobe[b], o_data[b*12+:12]} = desc(i_lane_data[b*12+:12], i_bus_strobe_lane[b], i_width);
   end
endmodule // lsp_rx_model

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import lsp_pkg::*;
   typedef struct {
      logic [47:0] lanes;
      logic [3:0]  sl;
      logic [47:0] orig;
      logic [3:0]  os;
      logic        rx;
   } lsp_exp_t;

   logic        i_clk, i_reset, i_psel, i_penable, i_pwrite, i_link_clk, i_pattern_toggle_pin;
   logic [11:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata;
   logic        o_pready, o_pslverr, chk_on, wh, mk;
   logic [47:0] i_sample, o_lane_data, rx_data, smp;
   logic [3:0]  i_strobe, i_marker, o_bus_strobe_lane, rx_strobe, stb, mrk;
   logic [1:0]  w;
   logic [31:0] sd, r1, r2;
   logic [11:0] upat [8];
   logic [11:0] d;
   lsp_exp_t    e, e2;
   lsp_exp_t    q [$];
   int          n_mismatch, tests_run, p, cur, nxt, cyc;

   lsp_output_top #(.NUM_BUS(4)) DUT (.i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr), .i_link_clk(i_link_clk), .i_sample(i_sample), .i_strobe(i_strobe),
      .i_marker(i_marker), .i_pattern_toggle_pin(i_pattern_toggle_pin), .o_lane_data(o_lane_data),
      .o_bus_strobe_lane(o_bus_strobe_lane));
   lsp_rx_model #(.NUM_BUS(4)) u_rx (.i_lane_data(o_lane_data), .i_bus_strobe_lane(o_bus_strobe_lane),
      .i_width(w), .o_data(rx_data), .o_strobe(rx_strobe));

   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   initial begin
      i_link_clk = 1'b0;
      #3.1;
      forever #7.5 i_link_clk = ~i_link_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   function automatic logic [12:0] whitening_enable(input logic [11:0] v, input logic s, input logic [1:0] wd, input logic m);
      logic [11:0] y;
      logic        t;
      y = v;
      case (wd)
         LSP_W12: begin
            for (int k = 2; k < 12; k++) y[k] = v[k] ^ v[1] ^ v[0];
            y[0] = v[0] ^ v[1];
            t = s ^ v[1] ^ v[0];
         end
         LSP_W11: begin
            for (int k = 3; k < 12; k++) y[k] = v[k] ^ v[2] ^ v[1];
            y[1] = v[2] ^ v[1];
            y[0] = v[2] ^ v[1] ^ v[0];
            t = s ^ v[1] ^ v[0];
         end
         LSP_W10: begin
            for (int k = 4; k < 12; k++) y[k] = v[k] ^ v[3] ^ v[2];
            y[2] = v[2] ^ v[3];
            y[1] = 1'b0;
            y[0] = v[0] ^ v[3] ^ v[2];
            t = s ^ v[3] ^ v[2];
         end
         default: begin
            for (int k = 6; k < 12; k++) y[k] = v[k] ^ v[5] ^ v[4];
            y[4] = v[4] ^ v[5];
            y[3:1] = 3'h0;
            y[0] = v[0] ^ v[5] ^ v[4];
            t = s ^ v[5] ^ v[4];
         end
      endcase
      if (wd != LSP_W12 && !m) y[0] = 1'b0;
      return {t, y};
   endfunction

   task automatic check(input logic [47:0] seen, input logic [47:0] xp);
      tests_run++;
      if (seen !== xp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, xp);
      end
   endtask

   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   // link-side driver: strobe 0 high on the tenth sample, so frames are ten samples long
   always @(posedge i_link_clk) begin
      r1 = lfsr(r2);
      r2 = lfsr(r1);
      p = (p == 9) ? 0 : p + 1;
      if (p == 0) cur = nxt;
      smp = {r1, r2[15:0]};
      stb = {r2[18:16], p == 9};
      mrk = r2[22:19];
      i_sample <= smp;
      i_strobe <= stb;
      i_marker <= mrk;
      for (int b = 0; b < 4; b++) begin
         d = smp[b*12+:12];
         case (cur)
            0: if (mk) d[0] = mrk[b];
            1: d = upat[p%8];
            2: d = {12{stb[b]}};
            default: d[0] = stb[b];
         endcase
         {e.sl[b], e.lanes[b*12+:12]} = wh ? whitening_enable(d, stb[b], w, mk) : {stb[b], d};
         if (w == LSP_W10) d[1] = 1'b0;
         if (w == LSP_W8) d[3:1] = 3'h0;
         e.orig[b*12+:12] = d;
         e.os[b] = stb[b];
      end
      e.rx = wh && cur == 0 && (mk || w == LSP_W12);
      if (chk_on) q.push_back(e);
      else q.delete();
   end

   // one link cycle of latency: the oldest note belongs to what is on the lanes now
   always @(negedge i_link_clk) begin
      if (q.size() >= 2) begin
         e2 = q.pop_front();
         check(o_lane_data, e2.lanes);
         check(48'(o_bus_strobe_lane), 48'(e2.sl));
         if (e2.rx) check(rx_data, e2.orig);
         // stated odd-width strobe equations do not invert, so skip that one
         if (e2.rx && w != LSP_W11) check(48'(rx_strobe), 48'(e2.os));
      end
   end

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [31:0] xd,
                      input logic xe);
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= wd;
      @(posedge i_clk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_clk);
      end while (o_pready !== 1'b1);
      if (!wr) check(48'(o_prdata), 48'(xd));
      check(48'(o_pslverr), 48'(xe));
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask

   task automatic run_cfg(input logic nwh, input logic [1:0] nw, input logic nmk, input logic [31:0] ex,
                          input logic [2:0] ts, input int k, input int n);
      @(posedge i_link_clk);
      chk_on <= 1'b0;
      apb(1'b1, LSP_OFS_CTRL, ex | (32'(nmk) << LSP_CTRL_MARKER) | (32'(nw) << LSP_CTRL_WIDTH) | 32'(nwh), 0, 0);
      apb(1'b1, LSP_OFS_TSRC, 32'(ts), 0, 0);
      wh = nwh;
      w = nw;
      mk = nmk;
      nxt = k;
      // config crosses as plain levels, so let it settle well past a frame
      repeat (25) @(posedge i_link_clk);
      chk_on <= 1'b1;
      repeat (n) @(posedge i_link_clk);
      $display("test done: whiten %0d width %0d marker %0d pattern %0d", nwh, nw, nmk, k);
   endtask

   task automatic toggle(input logic v, input int k);
      do @(negedge i_link_clk); while (p != 1);
      nxt = k;
      @(posedge i_link_clk);
      i_pattern_toggle_pin <= v;
      repeat (30) @(posedge i_link_clk);
      $display("test done: pin toggled to %0d", v);
   endtask

   initial begin
      {i_psel, i_penable, i_pwrite, i_pattern_toggle_pin, chk_on, wh, mk} = '0;
      {i_paddr, i_pwdata, i_sample, i_strobe, i_marker, w} = '0;
      {n_mismatch, tests_run, p, cur, nxt, cyc} = '0;
      sd = 32'h0001_0F5F;
      r2 = sd;
      i_reset = 1'b1;
      repeat (10) @(posedge i_clk);
      i_reset <= 1'b0;
      apb(1'b0, LSP_OFS_CTRL, 0, 32'(LSP_CTRL_RST), 0);
      apb(1'b0, LSP_OFS_TSRC, 0, 32'(LSP_TSRC_RST), 0);
      apb(1'b0, LSP_OFS_STAT, 0, 0, 0);
      apb(1'b0, LSP_OFS_UPAT, 0, 32'(LSP_UPAT_RST), 0);
      apb(1'b0, 12'h010, 0, 0, 1);
      apb(1'b1, LSP_OFS_CTRL, 32'hFFFFFFFF, 0, 0);
      apb(1'b0, LSP_OFS_CTRL, 0, 32'h0000007F, 0);
      for (int i = 0; i < 8; i++) begin
         sd = lfsr(lfsr(sd));
         upat[i] = sd[11:0];
         apb(1'b1, LSP_OFS_UPAT + 12'(4 * i), 32'(sd[11:0]), 0, 0);
      end
      apb(1'b0, LSP_OFS_UPAT + 12'h01C, 0, 32'(upat[7]), 0);
      $display("test done: registers");
      for (int i = 0; i < 8; i++) run_cfg(1'b1, 2'(i / 2), 1'(i % 2), 0, 3'h0, 0, 40);
      run_cfg(1'b0, LSP_W10, 1'b0, 0, 3'h0, 0, 40);
      run_cfg(1'b0, LSP_W12, 1'b0, 0, 3'h1, 1, 40);
      @(posedge i_link_clk);
      i_pattern_toggle_pin <= 1'b1;
      run_cfg(1'b0, LSP_W12, 1'b0, 0, {LSP_ALN_USER, 1'b0}, 1, 30);
      run_cfg(1'b0, LSP_W12, 1'b0, 0, {LSP_ALN_LSB, 1'b0}, 3, 30);
      run_cfg(1'b0, LSP_W12, 1'b0, 0, {2'h3, 1'b0}, 1, 30);
      run_cfg(1'b0, LSP_W12, 1'b0, 0, {LSP_ALN_ALL, 1'b0}, 2, 30);
      apb(1'b0, LSP_OFS_STAT, 0, 32'h00000003, 0);
      toggle(1'b0, 0);
      toggle(1'b1, 2);
      toggle(1'b0, 0);
      run_cfg(1'b0, LSP_W12, 1'b0, 32'h00000060, {LSP_ALN_ALL, 1'b0}, 2, 30);
      wrap_up();
   end
endmodule // tb_top
